// ---- src/dtcei_top.sv ----
// dual timer/counter with external interrupt flags
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module dtcei_top
  import dtcei_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  input wire logic POWER_DOWN_REQUEST,
  input wire logic IDLE_REQUEST,
  input wire logic TIMER_ZERO_VECTORED,
  input wire logic TIMER_ONE_VECTORED,
  input wire logic EXT_ZERO_VECTORED,
  input wire logic EXT_ONE_VECTORED,
  input wire logic EXT_IRQ_PIN_ZERO_N,
  input wire logic EXT_IRQ_PIN_ONE_N,
  input wire logic COUNT_PIN_ZERO,
  input wire logic COUNT_PIN_ONE,
  output logic OVERFLOW_FLAG_ZERO,
  output logic OVERFLOW_FLAG_ONE,
  output logic EXT_REQUEST_FLAG_ZERO,
  output logic EXT_REQUEST_FLAG_ONE
);
  import dtcei_pkg::*;

  // ----------------------------------------------------------------
  // registers and wires
  // ----------------------------------------------------------------
  logic [7:0] ctl_r;
  logic [7:0] timer_mode_select_r;
  logic [7:0] clock_divider_control_r;
  logic [7:0] tl0_r;
  logic [7:0] th0_r;
  logic [7:0] tl1_r;
  logic [7:0] th1_r;
  logic [3:0] div4_r;
  logic [3:0] div12_r;
  logic ext_irq_pin_zero_q_r;
  logic ext_irq_pin_one_q_r;
  logic t0p_q_r;
  logic t1p_q_r;
  logic ext_irq_pin_zero_lvl;
  logic ext_irq_pin_one_lvl;
  logic t0p_lvl;
  logic t1p_lvl;

  // pin synchronisers
  dtcei_pin_sync u_sync_ext_irq_pin_zero (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .pin_in(EXT_IRQ_PIN_ZERO_N), .level_out(ext_irq_pin_zero_lvl));
  dtcei_pin_sync u_sync_ext_irq_pin_one (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .pin_in(EXT_IRQ_PIN_ONE_N), .level_out(ext_irq_pin_one_lvl));
  dtcei_pin_sync u_sync_t0 (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .pin_in(COUNT_PIN_ZERO), .level_out(t0p_lvl));
  dtcei_pin_sync u_sync_t1 (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .pin_in(COUNT_PIN_ONE), .level_out(t1p_lvl));

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  function automatic logic count_enable(input logic run, input logic gate, input logic pin_high);
    count_enable = run && (!gate || pin_high);
  endfunction

  // one counting step in the given mode: overflow, high byte, low byte
  function automatic logic [16:0] count_step(input logic [1:0] mode, input logic [7:0] lo, input logic [7:0] hi);
    logic prescale_full;
    logic [7:0] lo_inc;
    logic [15:0] word_inc;
    prescale_full = ((lo & PRESCALE_MASK) == PRESCALE_MASK);
    lo_inc = lo + 8'h01;
    word_inc = {hi, lo} + 16'h0001;
    case (mode)
      DTCEI_MODE_13BIT:
      begin
        // prescaler in the low five bits carries into the high byte
        count_step = {1'b0, hi, lo_inc & PRESCALE_MASK};
        if (prescale_full)
          count_step = {hi == 8'hFF, hi + 8'h01, lo_inc & PRESCALE_MASK};
      end
      DTCEI_MODE_16BIT: count_step = {word_inc == 16'h0000, word_inc};
      DTCEI_MODE_RELOAD: count_step = {lo == 8'hFF, hi, (lo == 8'hFF) ? hi : lo_inc};
      default: count_step = {lo == 8'hFF, hi, lo_inc};
    endcase
  endfunction

  wire clk_on = !POWER_DOWN_REQUEST;
  wire wr_ctl = SFR_WR && (SFR_ADDR == ADDR_TIMER_CONTROL);
  wire wr_timer_mode_select = SFR_WR && (SFR_ADDR == ADDR_TIMER_MODE_SELECT);
  wire wr_ck = SFR_WR && (SFR_ADDR == ADDR_CLOCK_DIVIDER_CONTROL);
  wire wr_tl0 = SFR_WR && (SFR_ADDR == ADDR_TIMER_0_LOW_BYTE);
  wire wr_th0 = SFR_WR && (SFR_ADDR == ADDR_TIMER_0_HIGH_BYTE);
  wire wr_tl1 = SFR_WR && (SFR_ADDR == ADDR_TIMER_1_LOW_BYTE);
  wire wr_th1 = SFR_WR && (SFR_ADDR == ADDR_TIMER_1_HIGH_BYTE);
  wire [3:0] tm0 = timer_mode_select_r[3:0];
  wire [3:0] tm1 = timer_mode_select_r[7:4];
  wire [1:0] mode0 = tm0[BIT_MODE_SELECT_HIGH:BIT_MODE_SELECT_LOW];
  wire [1:0] mode1 = tm1[BIT_MODE_SELECT_HIGH:BIT_MODE_SELECT_LOW];
  wire run0 = ctl_r[BIT_RUN_BIT_ZERO];
  wire run1 = ctl_r[BIT_RUN_BIT_ONE];

  // internal tick strobes: divide by 4 or 12
  wire tick4 = clk_on && (div4_r == DIV_FAST - 4'h1);
  wire tick12 = clk_on && (div12_r == DIV_SLOW - 4'h1);
  wire itick0 = clock_divider_control_r[BIT_CLOCK_DIV_SELECT_ZERO] ? tick4 : tick12;
  wire itick1 = clock_divider_control_r[BIT_CLOCK_DIV_SELECT_ONE] ? tick4 : tick12;
  // falling edges on count pins
  wire t0_fall = clk_on && t0p_q_r && !t0p_lvl;
  wire t1_fall = clk_on && t1p_q_r && !t1p_lvl;
  wire src0 = tm0[BIT_COUNTER_SELECT] ? t0_fall : itick0;
  wire src1 = tm1[BIT_COUNTER_SELECT] ? t1_fall : itick1;
  // enables, gating by pin level (active-low pin high = idle)
  wire en0 = count_enable(run0, tm0[BIT_GATE], ext_irq_pin_zero_lvl);
  wire en1 = count_enable(run1, tm1[BIT_GATE], ext_irq_pin_one_lvl);
  wire inc0 = en0 && src0;
  // timer 1 counts unless in mode 3
  wire inc1 = en1 && src1 && (mode1 != DTCEI_MODE_SPLIT);
  // split mode: th0 runs from run_bit_one on internal clock
  wire inc0h = (mode0 == DTCEI_MODE_SPLIT) && run1 && itick0;

  // count steps for both timers; split mode adds the high byte of timer 0
  wire [16:0] step0 = count_step(mode0, tl0_r, th0_r);
  wire [16:0] step1 = count_step(mode1, tl1_r, th1_r);
  wire ovf0 = inc0 && step0[16];
  wire ovf1 = inc1 && step1[16];
  wire ovf0h = inc0h && (th0_r == 8'hFF);
  wire [7:0] tl0_nxt = inc0 ? step0[7:0] : tl0_r;
  wire [7:0] th0_nxt = inc0h ? th0_r + 8'h01 : (inc0 ? step0[15:8] : th0_r);
  wire [7:0] tl1_nxt = inc1 ? step1[7:0] : tl1_r;
  wire [7:0] th1_nxt = inc1 ? step1[15:8] : th1_r;

  // external interrupt detection
  wire fall0 = clk_on && ext_irq_pin_zero_q_r && !ext_irq_pin_zero_lvl;
  wire fall1 = clk_on && ext_irq_pin_one_q_r && !ext_irq_pin_one_lvl;
  wire edge_mode0 = ctl_r[BIT_EXT_TRIGGER_TYPE_ZERO];
  wire edge_mode1 = ctl_r[BIT_EXT_TRIGGER_TYPE_ONE];

  // timer control next value; hardware sets beat clears
  logic [7:0] ctl_nxt;
  wire set_tf0 = ovf0;
  wire set_tf1 = ovf1 || ovf0h;

  always_comb
  begin
    ctl_nxt = wr_ctl ? SFR_WDATA : ctl_r;
    if (TIMER_ZERO_VECTORED)
      ctl_nxt[BIT_OVERFLOW_FLAG_ZERO] = 1'b0;
    if (TIMER_ONE_VECTORED)
      ctl_nxt[BIT_OVERFLOW_FLAG_ONE] = 1'b0;
    if (set_tf0)
      ctl_nxt[BIT_OVERFLOW_FLAG_ZERO] = 1'b1;
    if (set_tf1)
      ctl_nxt[BIT_OVERFLOW_FLAG_ONE] = 1'b1;
    if (edge_mode0)
    begin
      if (EXT_ZERO_VECTORED)
        ctl_nxt[BIT_EXT_REQUEST_FLAG_ZERO] = 1'b0;
      if (fall0)
        ctl_nxt[BIT_EXT_REQUEST_FLAG_ZERO] = 1'b1;
    end
    else
      ctl_nxt[BIT_EXT_REQUEST_FLAG_ZERO] = !ext_irq_pin_zero_lvl;
    if (edge_mode1)
    begin
      if (EXT_ONE_VECTORED)
        ctl_nxt[BIT_EXT_REQUEST_FLAG_ONE] = 1'b0;
      if (fall1)
        ctl_nxt[BIT_EXT_REQUEST_FLAG_ONE] = 1'b1;
    end
    else
      ctl_nxt[BIT_EXT_REQUEST_FLAG_ONE] = !ext_irq_pin_one_lvl;
  end

  // read mux
  logic [7:0] rdata_nxt;
  always_comb
  begin
    case (SFR_ADDR)
      ADDR_TIMER_CONTROL: rdata_nxt = ctl_r;
      ADDR_TIMER_MODE_SELECT: rdata_nxt = timer_mode_select_r;
      ADDR_TIMER_0_LOW_BYTE: rdata_nxt = tl0_r;
      ADDR_TIMER_1_LOW_BYTE: rdata_nxt = tl1_r;
      ADDR_TIMER_0_HIGH_BYTE: rdata_nxt = th0_r;
      ADDR_TIMER_1_HIGH_BYTE: rdata_nxt = th1_r;
      ADDR_CLOCK_DIVIDER_CONTROL: rdata_nxt = clock_divider_control_r;
      default: rdata_nxt = 8'hFF;
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // prescale dividers, frozen in power-down
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      div4_r <= 4'h0;
      div12_r <= 4'h0;
    end
    else if (clk_on)
    begin
      div4_r <= (div4_r == DIV_FAST - 4'h1) ? 4'h0 : div4_r + 4'h1;
      div12_r <= (div12_r == DIV_SLOW - 4'h1) ? 4'h0 : div12_r + 4'h1;
    end
  end

  // pin history for edge detection
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ext_irq_pin_zero_q_r <= 1'b1;
      ext_irq_pin_one_q_r <= 1'b1;
      t0p_q_r <= 1'b1;
      t1p_q_r <= 1'b1;
    end
    else
    begin
      ext_irq_pin_zero_q_r <= ext_irq_pin_zero_lvl;
      ext_irq_pin_one_q_r <= ext_irq_pin_one_lvl;
      t0p_q_r <= t0p_lvl;
      t1p_q_r <= t1p_lvl;
    end
  end

  // software writes override counting in the same cycle
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ctl_r <= RST_TIMER_CONTROL;
      timer_mode_select_r <= RST_TIMER_MODE_SELECT;
      clock_divider_control_r <= RST_CLOCK_DIVIDER_CONTROL;
      tl0_r <= RST_COUNT_BYTE;
      th0_r <= RST_COUNT_BYTE;
      tl1_r <= RST_COUNT_BYTE;
      th1_r <= RST_COUNT_BYTE;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      timer_mode_select_r <= wr_timer_mode_select ? SFR_WDATA : timer_mode_select_r;
      clock_divider_control_r <= wr_ck ? SFR_WDATA : clock_divider_control_r;
      tl0_r <= wr_tl0 ? SFR_WDATA : tl0_nxt;
      th0_r <= wr_th0 ? SFR_WDATA : th0_nxt;
      tl1_r <= wr_tl1 ? SFR_WDATA : tl1_nxt;
      th1_r <= wr_th1 ? SFR_WDATA : th1_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      SFR_RDATA <= 8'h00;
      OVERFLOW_FLAG_ZERO <= 1'b0;
      OVERFLOW_FLAG_ONE <= 1'b0;
      EXT_REQUEST_FLAG_ZERO <= 1'b0;
      EXT_REQUEST_FLAG_ONE <= 1'b0;
    end
    else
    begin
      SFR_RDATA <= SFR_RD ? rdata_nxt : SFR_RDATA;
      OVERFLOW_FLAG_ZERO <= ctl_nxt[BIT_OVERFLOW_FLAG_ZERO];
      OVERFLOW_FLAG_ONE <= ctl_nxt[BIT_OVERFLOW_FLAG_ONE];
      EXT_REQUEST_FLAG_ZERO <= ctl_nxt[BIT_EXT_REQUEST_FLAG_ZERO];
      EXT_REQUEST_FLAG_ONE <= ctl_nxt[BIT_EXT_REQUEST_FLAG_ONE];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_ovf0;
    set_tf0;
  endsequence

  AST_OVF_SETS_FLAG: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    s_ovf0 |=> ctl_r[BIT_OVERFLOW_FLAG_ZERO] && OVERFLOW_FLAG_ZERO)
    else $error("overflow did not set flag zero");

  AST_STOPPED_HOLDS: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (!run0 && mode0 != DTCEI_MODE_SPLIT && !wr_tl0 && !wr_th0) |=> ($stable(tl0_r) && $stable(th0_r)))
    else $error("timer zero changed while stopped");

  AST_EDGE_SETS_REQ: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (edge_mode0 && fall0) |=> ctl_r[BIT_EXT_REQUEST_FLAG_ZERO])
    else $error("falling edge did not set request zero");

  AST_LEVEL_TRACKS: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (!edge_mode1) |=> (ctl_r[BIT_EXT_REQUEST_FLAG_ONE] == !$past(ext_irq_pin_one_lvl)))
    else $error("level request one does not track pin");

  AST_GATE_BLOCKS: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (tm1[BIT_GATE] && !ext_irq_pin_one_lvl) |-> !inc1)
    else $error("gated timer one counted with pin low");

  AST_MODE3_T1_HOLD: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (mode1 == DTCEI_MODE_SPLIT && !wr_tl1 && !wr_th1) |=> ($stable(tl1_r) && $stable(th1_r)))
    else $error("timer one moved in mode 3");

  AST_RELOAD: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (inc0 && mode0 == DTCEI_MODE_RELOAD && tl0_r == 8'hFF && !wr_tl0) |=> (tl0_r == $past(th0_r)))
    else $error("low byte zero not reloaded");

  AST_DIV4_PERIOD: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (tick4 && clk_on) |=> (!tick4)[*3])
    else $error("divide by four tick spacing wrong");

  AST_POWER_DOWN: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (POWER_DOWN_REQUEST && !wr_tl1 && !wr_th1) |=> ($stable(tl1_r) && $stable(th1_r)))
    else $error("timer one moved in power-down");

  AST_IDLE_COUNTS: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (IDLE_REQUEST && run0 && tm0 == 4'h1 && itick0 && !wr_tl0 && !wr_th0) |=> (tl0_r != $past(tl0_r)))
    else $error("timer zero stopped in idle");

  AST_COUNT_EDGE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (run0 && tm0 == 4'h5 && t0_fall && !wr_tl0 && !wr_th0) |=> (tl0_r != $past(tl0_r)))
    else $error("count pin edge not counted");

  AST_VECTOR_CLEARS: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (edge_mode0 && EXT_ZERO_VECTORED && !fall0 && !wr_ctl) |=> !ctl_r[BIT_EXT_REQUEST_FLAG_ZERO])
    else $error("vector did not clear request zero");

  AST_SPLIT_OVF: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (inc0h && th0_r == 8'hFF) |=> (ctl_r[BIT_OVERFLOW_FLAG_ONE] && OVERFLOW_FLAG_ONE))
    else $error("split high byte overflow did not set flag one");
endmodule

// ---- shared/dtcei_pkg.sv ----
// package of offsets, field positions and constants for the dual timer/counter block
package dtcei_pkg;
  // special function register addresses
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE_SELECT = 8'h89;
  localparam logic [7:0] ADDR_TIMER_0_LOW_BYTE = 8'h8A;
  localparam logic [7:0] ADDR_TIMER_1_LOW_BYTE = 8'h8B;
  localparam logic [7:0] ADDR_TIMER_0_HIGH_BYTE = 8'h8C;
  localparam logic [7:0] ADDR_TIMER_1_HIGH_BYTE = 8'h8D;
  localparam logic [7:0] ADDR_CLOCK_DIVIDER_CONTROL = 8'h8E;
  // reset values
  localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] RST_TIMER_MODE_SELECT = 8'h00;
  localparam logic [7:0] RST_COUNT_BYTE = 8'h00;
  localparam logic [7:0] RST_CLOCK_DIVIDER_CONTROL = 8'h00;
  // timer control field positions
  localparam int BIT_OVERFLOW_FLAG_ONE = 7;
  localparam int BIT_RUN_BIT_ONE = 6;
  localparam int BIT_OVERFLOW_FLAG_ZERO = 5;
  localparam int BIT_RUN_BIT_ZERO = 4;
  localparam int BIT_EXT_REQUEST_FLAG_ONE = 3;
  localparam int BIT_EXT_TRIGGER_TYPE_ONE = 2;
  localparam int BIT_EXT_REQUEST_FLAG_ZERO = 1;
  localparam int BIT_EXT_TRIGGER_TYPE_ZERO = 0;
  // mode select field positions, timer 1 in the upper nibble
  localparam int BIT_GATE = 3;
  localparam int BIT_COUNTER_SELECT = 2;
  localparam int BIT_MODE_SELECT_HIGH = 1;
  localparam int BIT_MODE_SELECT_LOW = 0;
  localparam int NIBBLE_TIMER_ONE = 4;
  // clock divider control field positions
  localparam int BIT_CLOCK_DIV_SELECT_ONE = 4;
  localparam int BIT_CLOCK_DIV_SELECT_ZERO = 3;
  // internal count clock division
  localparam logic [3:0] DIV_FAST = 4'h4;
  localparam logic [3:0] DIV_SLOW = 4'hC;
  // prescaler width in mode 0
  localparam logic [7:0] PRESCALE_MASK = 8'h1F;
  // timer modes
  typedef enum logic [1:0]
  {
    DTCEI_MODE_13BIT = 2'b00,
    DTCEI_MODE_16BIT = 2'b01,
    DTCEI_MODE_RELOAD = 2'b10,
    DTCEI_MODE_SPLIT = 2'b11
  } dtcei_mode_e;
endpackage

// ---- src/dtcei_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dtcei_pin_sync
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // first stage is read only by the second
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level_out <= 1'b1;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_out <= s3_r;
    end
  end
endmodule

// ---- test/dtcei_pin_model.sv ----
// pin-side partner: external interrupt pins and count-pin falling edges
`timescale 1ns/1ps
module dtcei_pin_model
(
  input wire logic clk_sys,
  input wire logic [1:0] irq_low,
  input wire logic edge_start,
  input wire logic edge_sel,
  input wire logic [7:0] edge_count,
  output logic edge_busy,
  output logic irq_pin_zero_n,
  output logic irq_pin_one_n,
  output logic count_pin_zero,
  output logic count_pin_one
);
  logic [7:0] left_r;
  logic [3:0] phase_r;
  logic sel_r;

  // ------------------------------------------------------------
  // pins idle high
  // ------------------------------------------------------------
  initial
  begin
    left_r = 8'h00;
    phase_r = 4'h0;
    sel_r = 1'b0;
    irq_pin_zero_n = 1'b1;
    irq_pin_one_n = 1'b1;
    count_pin_zero = 1'b1;
    count_pin_one = 1'b1;
  end

  // each count edge is 8 cycles low then 8 high, long enough for the pin filter
  always @(posedge clk_sys)
  begin
    irq_pin_zero_n <= !irq_low[0];
    irq_pin_one_n <= !irq_low[1];
    if (edge_start)
    begin
      left_r <= edge_count;
      phase_r <= 4'h0;
      sel_r <= edge_sel;
    end
    else if (left_r != 8'h00)
    begin
      phase_r <= phase_r + 4'h1;
      if (phase_r == 4'h0)
      begin
        if (sel_r)
          count_pin_one <= 1'b0;
        else
          count_pin_zero <= 1'b0;
      end
      if (phase_r == 4'h8)
      begin
        count_pin_zero <= 1'b1;
        count_pin_one <= 1'b1;
        left_r <= left_r - 8'h01;
      end
    end
  end

  assign edge_busy = (left_r != 8'h00);
endmodule

// ---- test/dual_timer_counter_ext_irq_tb.sv ----
// self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
module dual_timer_counter_ext_irq_tb;
  import dtcei_pkg::*;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rst; logic [7:0] exp;} dtcei_row_s;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic pd = 1'b0;
  logic idle = 1'b0;
  logic [3:0] vec = 4'h0;
  logic [1:0] irq_low = 2'b00;
  logic edge_start = 1'b0;
  logic edge_sel = 1'b0;
  logic edge_busy;
  logic irq0_n, irq1_n, cnt0, cnt1;
  logic [3:0] flags;
  logic [7:0] va, vb;
  int err_total = 0;
  int comparisons = 0;
  dtcei_row_s rows [8] = '{
    '{ADDR_TIMER_MODE_SELECT, 8'h5A, RST_TIMER_MODE_SELECT, 8'h5A},
    '{ADDR_TIMER_0_LOW_BYTE, 8'h12, RST_COUNT_BYTE, 8'h12},
    '{ADDR_TIMER_1_LOW_BYTE, 8'h34, RST_COUNT_BYTE, 8'h34},
    '{ADDR_TIMER_0_HIGH_BYTE, 8'h56, RST_COUNT_BYTE, 8'h56},
    '{ADDR_TIMER_1_HIGH_BYTE, 8'h78, RST_COUNT_BYTE, 8'h78},
    '{ADDR_CLOCK_DIVIDER_CONTROL, 8'h18, RST_CLOCK_DIVIDER_CONTROL, 8'h18},
    '{8'h87, 8'h55, 8'hFF, 8'hFF},
    '{ADDR_TIMER_CONTROL, 8'h0F, RST_TIMER_CONTROL, 8'h05}}; // level mode still holds the request bits

  // ------------------------------------------------------------
  // clock, design and pin partner
  // ------------------------------------------------------------
  always #2.5 clk_sys = ~clk_sys;

  dtcei_top dtcei_top_inst (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata),
    .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata), .POWER_DOWN_REQUEST(pd), .IDLE_REQUEST(idle),
    .TIMER_ZERO_VECTORED(vec[0]), .TIMER_ONE_VECTORED(vec[1]), .EXT_ZERO_VECTORED(vec[2]),
    .EXT_ONE_VECTORED(vec[3]), .EXT_IRQ_PIN_ZERO_N(irq0_n), .EXT_IRQ_PIN_ONE_N(irq1_n),
    .COUNT_PIN_ZERO(cnt0), .COUNT_PIN_ONE(cnt1), .OVERFLOW_FLAG_ZERO(flags[0]),
    .OVERFLOW_FLAG_ONE(flags[1]), .EXT_REQUEST_FLAG_ZERO(flags[2]), .EXT_REQUEST_FLAG_ONE(flags[3]));

  dtcei_pin_model dtcei_pin_model_inst (.clk_sys(clk_sys), .irq_low(irq_low), .edge_start(edge_start),
    .edge_sel(edge_sel), .edge_count(8'h05), .edge_busy(edge_busy), .irq_pin_zero_n(irq0_n),
    .irq_pin_one_n(irq1_n), .count_pin_zero(cnt0), .count_pin_one(cnt1));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    @(posedge clk_sys);
    #1 d = sfr_rdata;
  endtask

  task automatic pulse_vec(input int i);
    @(negedge clk_sys);
    vec[i] = 1'b1;
    @(negedge clk_sys);
    vec = 4'h0;
  endtask

  // flag must rise no sooner than lo and no later than hi cycles
  task automatic wait_flag(input int idx, input int lo, input int hi);
    int n;
    n = 0;
    while (flags[idx] !== 1'b1 && n <= hi)
    begin
      @(negedge clk_sys);
      n++;
    end
    check({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask

  // stop both timers, load mode and counts, then start with the given control value
  task automatic setup(input logic [7:0] timer_mode_select, input logic [7:0] tl, input logic [7:0] th, input logic [7:0] timer_control);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_TIMER_MODE_SELECT, timer_mode_select);
    wr(ADDR_TIMER_0_LOW_BYTE, tl);
    wr(ADDR_TIMER_1_LOW_BYTE, tl);
    wr(ADDR_TIMER_0_HIGH_BYTE, th);
    wr(ADDR_TIMER_1_HIGH_BYTE, th);
    wr(ADDR_TIMER_CONTROL, timer_control);
  endtask

  // ------------------------------------------------------------
  // watchdog: the whole run needs a little over a thousand cycles
  // ------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
    check({4'h0, flags}, 8'h00);
    // register table rows: reset value, write, read back
    foreach (rows[i])
    begin
      rd(rows[i].addr, va);
      check(va, rows[i].rst);
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, va);
      check(va, rows[i].exp);
    end
    // edge mode now in force, so software may set the request bits
    wr(ADDR_TIMER_CONTROL, 8'h0F);
    check({4'h0, flags}, 8'h0C);
    pulse_vec(2);
    check({4'h0, flags}, 8'h08);
    pulse_vec(3);
    check({4'h0, flags}, 8'h00);
    // overflow flags: software set, vector clear, software clear
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_TIMER_CONTROL, i ? 8'h80 : 8'h20);
      check({7'h00, flags[i]}, 8'h01);
      pulse_vec(i);
      check({7'h00, flags[i]}, 8'h00);
      wr(ADDR_TIMER_CONTROL, i ? 8'h80 : 8'h20);
      wr(ADDR_TIMER_CONTROL, 8'h00);
      check({7'h00, flags[i]}, 8'h00);
    end
    // counting modes, 16 or 4 ticks to overflow
    setup(8'h01, 8'hF0, 8'hFF, 8'h10);
    wait_flag(0, 56, 72);
    rd(ADDR_TIMER_0_HIGH_BYTE, va);
    check(va, 8'h00);
    setup(8'h10, 8'hF0, 8'hFF, 8'h40);
    wait_flag(1, 56, 72);
    wr(ADDR_CLOCK_DIVIDER_CONTROL, 8'h00);
    setup(8'h01, 8'hF0, 8'hFF, 8'h10);
    wait_flag(0, 176, 204);
    wr(ADDR_CLOCK_DIVIDER_CONTROL, 8'h18);
    setup(8'h00, 8'h1C, 8'hFF, 8'h10);
    wait_flag(0, 10, 22);
    rd(ADDR_TIMER_0_HIGH_BYTE, va);
    check(va, 8'h00);
    setup(8'h02, 8'hFC, 8'hF0, 8'h10);
    wait_flag(0, 10, 22);
    rd(ADDR_TIMER_0_HIGH_BYTE, va);
    check(va, 8'hF0);
    rd(ADDR_TIMER_0_LOW_BYTE, va);
    check({va[7:4], 4'h0}, 8'hF0);
    setup(8'h33, 8'h00, 8'hFC, 8'h40);
    wait_flag(1, 10, 22);
    rd(ADDR_TIMER_0_LOW_BYTE, va);
    check(va, 8'h00);
    rd(ADDR_TIMER_1_LOW_BYTE, va);
    check(va, 8'h00);
    setup(8'h01, 8'h00, 8'h00, 8'h00);
    cycles(40);
    rd(ADDR_TIMER_0_LOW_BYTE, va);
    check(va, 8'h00);
    // gate holds the timer while its interrupt pin is low
    irq_low = 2'b01;
    setup(8'h09, 8'h00, 8'h00, 8'h10);
    cycles(40);
    rd(ADDR_TIMER_0_LOW_BYTE, va);
    check(va, 8'h00);
    irq_low = 2'b00;
    cycles(40);
    rd(ADDR_TIMER_0_LOW_BYTE, va);
    check({7'h00, va != 8'h00}, 8'h01);
    // counter mode: five pin edges, no internal ticks
    for (int i = 0; i < 2; i++)
    begin
      setup(i ? 8'h50 : 8'h05, 8'h00, 8'h00, i ? 8'h40 : 8'h10);
      edge_sel = i[0];
      edge_start = 1'b1;
      cycles(1);
      edge_start = 1'b0;
      cycles(2);
      for (int n = 0; n < 200 && edge_busy; n++)
        cycles(1);
      cycles(10);
      rd(i ? ADDR_TIMER_1_LOW_BYTE : ADDR_TIMER_0_LOW_BYTE, va);
      check(va, 8'h05);
    end
    // power-down freezes the count, idle does not
    setup(8'h01, 8'h00, 8'h00, 8'h10);
    cycles(20);
    pd = 1'b1;
    cycles(4);
    rd(ADDR_TIMER_0_LOW_BYTE, va);
    cycles(40);
    rd(ADDR_TIMER_0_LOW_BYTE, vb);
    check(vb, va);
    pd = 1'b0;
    idle = 1'b1;
    rd(ADDR_TIMER_0_LOW_BYTE, va);
    cycles(40);
    rd(ADDR_TIMER_0_LOW_BYTE, vb);
    check({7'h00, vb != va}, 8'h01);
    idle = 1'b0;
    // external requests: low level tracks the pin, falling edge latches until vectored
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_TIMER_CONTROL, 8'h00);
      irq_low[i] = 1'b1;
      wait_flag(2 + i, 1, 12);
      irq_low[i] = 1'b0;
      cycles(10);
      check({7'h00, flags[2 + i]}, 8'h00);
      wr(ADDR_TIMER_CONTROL, i ? 8'h04 : 8'h01);
      irq_low[i] = 1'b1;
      cycles(12);
      irq_low[i] = 1'b0;
      cycles(12);
      check({7'h00, flags[2 + i]}, 8'h01);
      pulse_vec(2 + i);
      cycles(2);
      check({7'h00, flags[2 + i]}, 8'h00);
    end
    // reset in mid-run returns the registers to their reset values
    sys_rst = 1'b1;
    cycles(2);
    sys_rst = 1'b0;
    check({4'h0, flags}, 8'h00);
    rd(ADDR_TIMER_MODE_SELECT, va);
    check(va, RST_TIMER_MODE_SELECT);
    rd(ADDR_TIMER_0_LOW_BYTE, va);
    check(va, RST_COUNT_BYTE);
    finish_test();
  end
endmodule
